// *** rhco_act.sv ***
`timescale 1ns/100ps
`default_nettype none

module rhco_act (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] drive,
  input wire logic [3:0] send,
  output logic [3:0] valve,
  output logic [15:0] heard
);
  // The actuator acts on telegrams only, so a bit change without a send is never seen here.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      valve <= 4'h0;
      heard <= 16'h0000;
    end else begin
      valve <= (valve & ~send) | (drive & send);
      heard <= heard + 16'(send[0]);
    end
  end
endmodule

`default_nettype wire

// *** rhco_chk.sv ***
`timescale 1ns/100ps
`default_nettype none

module rhco_chk #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0][7:0] cont_value,
  input wire logic [3:0] cont_send,
  input wire logic [3:0] thermal_valve_drive,
  input wire logic [3:0] thermal_valve_send,
  input wire logic [3:0][7:0] status_value,
  input wire logic [3:0] status_send
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // The slave never inserts wait states, so a stuck pready would hang software.
  chk_pready_access: assert property (pready == (psel && penable))
    else $error("pready not tied to access phase");
  chk_err_unmapped: assert property (psel && penable && paddr > 8'h24 |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_err_aligned: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");

  // Byte telegrams are single pulses and the byte only moves with one.
  chk_cont_pulse: assert property (cont_send != 4'h0 |=> (cont_send & $past(cont_send)) == 4'h0)
    else $error("continuous send longer than a cycle");
  chk_cont_held: assert property ($past(cont_value) != cont_value |-> cont_send != 4'h0)
    else $error("continuous byte changed silently");

  // Every change of a switch bit travels with a telegram, so the actuator never misses one.
  chk_drive_sent: assert property (((thermal_valve_drive ^ $past(thermal_valve_drive)) & ~thermal_valve_send) == 4'h0)
    else $error("switch bit changed without telegram");
  chk_valve_pulse: assert property ((thermal_valve_send & $past(thermal_valve_send)) == 4'h0)
    else $error("switch telegram longer than a cycle");

  // Status bytes move only together with the switched telegram at a period start.
  chk_status_sync: assert property ((status_send & ~thermal_valve_send) == 4'h0)
    else $error("status sent apart from switch telegram");
  chk_status_held: assert property ($past(status_value) != status_value |-> status_send != 4'h0)
    else $error("status byte changed silently");
  chk_status_pulse: assert property (status_send != 4'h0 |=> status_send == 4'h0)
    else $error("status send longer than a cycle");

  cov_cont_send: cover property (cont_send[0]);
  cov_drive_rise: cover property ($rose(thermal_valve_drive[0]));
  cov_status_send: cover property (status_send[0]);
  cov_refused: cover property (psel && penable && pslverr);
endmodule

`default_nettype wire

// *** rhco_defs.svh ***
`ifndef RHCO_DEFS_SVH
`define RHCO_DEFS_SVH

// Clock rate and the slow time base.
`define RHCO_CLK_HZ 50000000
`define RHCO_TICK_S 1
`define RHCO_TICK_CYCLES (`RHCO_CLK_HZ * `RHCO_TICK_S)
`define RHCO_CALC_S 30

// Register byte offsets.
`define RHCO_OFF_CTRL 8'h00
`define RHCO_OFF_ROOM 8'h04
`define RHCO_OFF_SPHEAT 8'h08
`define RHCO_OFF_SPCOOL 8'h0C
`define RHCO_OFF_WIDTH 8'h10
`define RHCO_OFF_THR 8'h14
`define RHCO_OFF_CYCLE 8'h18
`define RHCO_OFF_GAIN 8'h1C
`define RHCO_OFF_VALUE 8'h20
`define RHCO_OFF_OUT 8'h24

// Control register fields.
`define RHCO_CTRL_EN 0
`define RHCO_CTRL_CHEN 1
`define RHCO_CTRL_MODE 5
`define RHCO_CTRL_STAT 9

// Reset values.
`define RHCO_RST_CTRL 10'h000
`define RHCO_RST_ROOM 16'h0834
`define RHCO_RST_SPHEAT 16'h0834
`define RHCO_RST_SPCOOL 16'h0960
`define RHCO_RST_WIDTH 16'h0064
`define RHCO_RST_THR 8'h05
`define RHCO_RST_CYCLE 16'h0258
`define RHCO_RST_GAIN 16'h0410

`endif

// *** rhco_pkg.sv ***
`default_nettype none

package rhco_pkg;

  typedef enum logic {
    RHCO_CONT = 1'b0,
    RHCO_SWITCH = 1'b1
  } rhco_mode_t;

  typedef struct packed {
    logic signed [15:0] integ;
    logic [7:0] value;
  } rhco_pi_t;

  typedef struct packed {
    logic [9:0] ctrl;
    logic [15:0] room;
    logic [15:0] sp_heat;
    logic [15:0] sp_cool;
    logic [15:0] width;
    logic [7:0] thr;
    logic [15:0] cycle;
    logic [15:0] gain;
    logic [25:0] sec_div;
    logic sec_tick;
    logic [4:0] calc_cnt;
    logic [15:0] period_cnt;
    logic period_start;
    logic [3:0][15:0] integ;
    logic [3:0][7:0] value;
    logic [3:0][7:0] last_sent;
    logic [3:0] cont_send;
    logic [31:0] prdata;
    logic pslverr;
  } rhco_state_t;

  typedef struct packed {
    logic active;
    logic [7:0] duty;
    logic drive;
    logic drive_send;
    logic [7:0] status;
    logic status_send;
  } rhco_chan_state_t;

endpackage

`default_nettype wire

// *** rhco_pwm_chan.sv ***
`timescale 1ns/100ps
`default_nettype none

module rhco_pwm_chan (
  input wire logic sys_clk,
  input wire logic rstn,
  rhco_pwm_if.chan pif
);

  rhco_pkg::rhco_chan_state_t st_reg;
  rhco_pkg::rhco_chan_state_t st_next;

  // Seconds of on-time within one period: duty share of the cycle time.
  function automatic logic [15:0] on_secs(input logic [7:0] duty, input logic [15:0] cyc);
    logic [23:0] prod;
    prod = 24'(duty) * 24'(cyc);
    return 16'(prod / 24'h00_00FF);
  endfunction

  // The duty factor is latched only at a period boundary, so setpoint changes wait for the period end; leaving switching mode drops the drive at once.
  always_comb begin
    st_next = st_reg;
    st_next.drive_send = 1'b0;
    st_next.status_send = 1'b0;
    if (!pif.enable || !pif.switching) begin
      st_next.active = 1'b0;
      st_next.drive = 1'b0;
      // An open valve gets an off telegram when the channel stops switching, so it cannot stay open.
      st_next.drive_send = st_reg.drive;
    end else if (pif.period_start) begin
      st_next.active = 1'b1;
      st_next.duty = pif.value;
      st_next.drive = (on_secs(pif.value, pif.cycle) != 16'h0000);
      st_next.drive_send = 1'b1;
      // The status byte only moves when it is also sent, so a listener never holds a stale copy.
      if (pif.stat_en) begin
        st_next.status = pif.value;
      end
      st_next.status_send = pif.stat_en;
    end else if (st_reg.active && st_reg.drive && pif.period_cnt >= on_secs(st_reg.duty, pif.cycle)) begin
      // Switch off once the on-share of the period has run out.
      st_next.drive = 1'b0;
      st_next.drive_send = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign pif.drive = st_reg.drive;
  assign pif.drive_send = st_reg.drive_send;
  assign pif.status = st_reg.status;
  assign pif.status_send = st_reg.status_send;

endmodule

`default_nettype wire

// *** rhco_pwm_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface rhco_pwm_if;
  logic period_start;
  logic [15:0] period_cnt;
  logic [15:0] cycle;
  logic [7:0] value;
  logic switching;
  logic enable;
  logic stat_en;
  logic drive;
  logic drive_send;
  logic [7:0] status;
  logic status_send;

  modport ctrl (
    output period_start, period_cnt, cycle, value, switching, enable, stat_en,
    input drive, drive_send, status, status_send
  );

  modport chan (
    input period_start, period_cnt, cycle, value, switching, enable, stat_en,
    output drive, drive_send, status, status_send
  );
endinterface

`default_nettype wire

// *** rhco_top.sv ***
// Overview of operation
// - A new command value is computed for every enabled channel once every 30 seconds.
// - In continuous mode the byte value is sent only when it moved by at least the percent threshold.
// - In switching mode the value becomes a PWM bit whose telegram goes out when the cycle time has elapsed.
// - The duty factor changes only at the end of a PWM period, whatever the size of the change.
// - In switching mode the change threshold and periodic sending settings have no effect.
// - At each period boundary the most recently computed value sets the next duty factor.
// - Setpoint or mode changes reach the switched output only after the running period ends; here leaving switching mode drops the output at once.
// - At 0 % or 100 % a constant off or on telegram is still sent at the end of every period.
// - In switching mode the internal byte value may also be output as a status byte per level.
// - Status bytes are updated together with the switched output, once per elapsed period.
// - All PWM outputs of every level and of heating and cooling share one cycle time.
// - An additional level runs the same algorithm with its setpoint offset by the level width.
// - Four independent channels exist: heating basic, heating extra, cooling basic, cooling extra.
// - The selected algorithm type per channel fixes its output as one bit or one byte.
// - Each command value derives from the difference of room temperature and active setpoint.
// - The cycle time sets the PWM period, so the on-share equals the averaged command value.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rhco_defs.svh"

module rhco_top #(
  parameter int TICK_CYCLES = `RHCO_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [3:0][7:0] cont_value,
  output logic [3:0] cont_send,
  output logic [3:0] thermal_valve_drive,
  output logic [3:0] thermal_valve_send,
  output logic [3:0][7:0] status_value,
  output logic [3:0] status_send
);

  // All block state lives in one packed struct; the next value is built in one place below.
  // Keeping it in one record means the reset branch and the register stage cannot drift apart.
  rhco_pkg::rhco_state_t st_reg;
  rhco_pkg::rhco_state_t st_next;
  // Per-channel results gathered back from the PWM channel instances.
  logic [3:0] drv_w;
  logic [3:0] drv_send_w;
  logic [3:0][7:0] stat_w;
  logic [3:0] stat_send_w;
  logic [15:0] cyc_eff;

  // True when the address names a register of this block.
  // Only whole aligned words are mapped; a byte or half-word address is refused with an error.
  function automatic logic addr_hit(input logic [7:0] a);
    return (a <= `RHCO_OFF_OUT) && (a[1:0] == 2'b00);
  endfunction

  // A channel runs only while both the block enable and its own enable bit are set.
  function automatic logic chan_on(input int ch, input rhco_pkg::rhco_state_t s);
    return s.ctrl[`RHCO_CTRL_EN] && s.ctrl[`RHCO_CTRL_CHEN + ch];
  endfunction

  // The per-channel mode bit selects a one-bit switched output or a one-byte continuous output.
  function automatic logic chan_switching(input int ch, input rhco_pkg::rhco_state_t s);
    return s.ctrl[`RHCO_CTRL_MODE + ch] == rhco_pkg::RHCO_SWITCH;
  endfunction

  // Active setpoint of a channel; extra levels sit one level width further out.
  // The extra heating level sits below the basic setpoint and the extra cooling level above it.
  function automatic logic [15:0] chan_sp(input int ch, input rhco_pkg::rhco_state_t s);
    logic [15:0] sp;
    unique case (ch)
      0: sp = s.sp_heat;
      1: sp = s.sp_heat - s.width;
      2: sp = s.sp_cool;
      default: sp = s.sp_cool + s.width;
    endcase
    return sp;
  endfunction

  // One PI step; the integral is clamped so a long deviation cannot wind up without end.
  // Temperatures are signed sixteen-bit words, so the error is formed one bit wider to avoid overflow.
  // The proportional gain is scaled by 1/64 and the integral gain by 1/256, which keeps both
  // products inside a 32-bit sum for every register setting.
  // The result is clamped to the byte range, so 8'h00 is fully closed and 8'hFF fully open.
  function automatic rhco_pkg::rhco_pi_t pi_step(
    input logic heat,
    input logic [15:0] sp,
    input logic [15:0] room,
    input logic [15:0] integ,
    input logic [15:0] gain
  );
    rhco_pkg::rhco_pi_t r;
    logic signed [16:0] err;
    logic signed [17:0] acc;
    logic signed [31:0] sum;
    logic signed [31:0] p_term;
    logic signed [31:0] i_term;
    // Heating acts when the room is below the setpoint, cooling when it is above.
    err = heat ? ($signed({sp[15], sp}) - $signed({room[15], room}))
               : ($signed({room[15], room}) - $signed({sp[15], sp}));
    // Saturate rather than wrap: a wrapped integral would swing the valve from open to closed.
    acc = $signed({integ[15], integ[15], integ}) + $signed({err[16], err});
    if (acc > 18'sh0_7FFF) begin
      r.integ = 16'sh7FFF;
    end else if (acc < -18'sh0_8000) begin
      r.integ = -16'sh8000;
    end else begin
      r.integ = 16'(acc);
    end
    p_term = (32'(err) * $signed({24'h00_0000, gain[7:0]})) >>> 6;
    i_term = (32'(r.integ) * $signed({24'h00_0000, gain[15:8]})) >>> 8;
    sum = p_term + i_term;
    if (sum < 0) begin
      r.value = 8'h00;
    end else if (sum > 32'sh0000_00FF) begin
      r.value = 8'hFF;
    end else begin
      r.value = 8'(sum);
    end
    return r;
  endfunction

  // Percent change test: a full byte step of 255 counts as 100 percent.
  // Both sides are scaled by integers, so no divider is needed for the comparison.
  // A threshold of zero lets every calculation through, which gives a plain 30 second refresh.
  function automatic logic moved_enough(input logic [7:0] nv, input logic [7:0] ov, input logic [7:0] thr);
    logic [7:0] d;
    d = (nv > ov) ? (nv - ov) : (ov - nv);
    return (17'(d) * 17'h0_0064) >= (17'(thr) * 17'h0_00FF);
  endfunction

  // Timing overview: a one-second enable drives both the PWM period counter and the
  // thirty-second calculation counter, so every channel sees the same period boundaries.
  // A faster tick for simulation is set through TICK_CYCLES without touching the logic.

  // A zero cycle time would stall the period, so it runs as one second.
  // A user must know that such a setting gives a one-second period rather than a stopped output.
  assign cyc_eff = (st_reg.cycle == 16'h0000) ? 16'h0001 : st_reg.cycle;

  // Next-state logic for timing, control law and register access.
  always_comb begin
    rhco_pkg::rhco_pi_t r;
    r = '0;
    st_next = st_reg;
    st_next.sec_tick = 1'b0;
    st_next.period_start = 1'b0;
    st_next.cont_send = 4'h0;

    // One-second enable from the clock divider.
    // The divider runs from reset, so the first second after enabling may be short by up to one tick.
    if (st_reg.sec_div >= 26'(TICK_CYCLES - 1)) begin
      st_next.sec_div = '0;
      st_next.sec_tick = 1'b1;
    end else begin
      st_next.sec_div = st_reg.sec_div + 26'h1;
    end

    // One period counter serves every channel, so all PWM outputs share the cycle time.
    // A shortened cycle time takes effect at once: the counter wraps on the next tick.
    if (!st_reg.ctrl[`RHCO_CTRL_EN]) begin
      st_next.period_cnt = '0;
    end else if (st_reg.sec_tick) begin
      if (st_reg.period_cnt >= cyc_eff - 16'h0001) begin
        st_next.period_cnt = '0;
        st_next.period_start = 1'b1;
      end else begin
        st_next.period_cnt = st_reg.period_cnt + 16'h0001;
      end
    end

    // Control law runs on a 30 second cadence.
    // Channels disabled by their own bit drop their integral so that re-enabling starts without stored windup; a block disable keeps it.
    if (!st_reg.ctrl[`RHCO_CTRL_EN]) begin
      st_next.calc_cnt = '0;
    end else if (st_reg.sec_tick) begin
      if (st_reg.calc_cnt == 5'(`RHCO_CALC_S - 1)) begin
        st_next.calc_cnt = '0;
        for (int i = 0; i < 4; i++) begin
          if (chan_on(i, st_reg)) begin
            r = pi_step(i < 2, chan_sp(i, st_reg), st_reg.room, st_reg.integ[i], st_reg.gain);
            st_next.integ[i] = r.integ;
            st_next.value[i] = r.value;
            // Threshold applies to continuous channels only; switching ones ignore it.
            // A switching channel picks up the new value at its next period start instead.
            if (!chan_switching(i, st_reg)
                && moved_enough(r.value, st_reg.last_sent[i], st_reg.thr)) begin
              st_next.last_sent[i] = r.value;
              st_next.cont_send[i] = 1'b1;
            end
          end else begin
            st_next.integ[i] = '0;
            st_next.value[i] = '0;
          end
        end
      end else begin
        st_next.calc_cnt = st_reg.calc_cnt + 5'h01;
      end
    end

    // Register writes take effect in the access phase.
    // The two read-only words fall to the default branch, so writing them is harmless.
    if (psel && penable && pwrite) begin
      unique case (paddr)
        `RHCO_OFF_CTRL: st_next.ctrl = pwdata[9:0];
        `RHCO_OFF_ROOM: st_next.room = pwdata[15:0];
        `RHCO_OFF_SPHEAT: st_next.sp_heat = pwdata[15:0];
        `RHCO_OFF_SPCOOL: st_next.sp_cool = pwdata[15:0];
        `RHCO_OFF_WIDTH: st_next.width = pwdata[15:0];
        `RHCO_OFF_THR: st_next.thr = pwdata[7:0];
        `RHCO_OFF_CYCLE: st_next.cycle = pwdata[15:0];
        `RHCO_OFF_GAIN: st_next.gain = pwdata[15:0];
        default: ;
      endcase
    end

    // Read data and error are captured in the setup phase so both come from flip-flops.
    // The trade-off is that a read returns the state of the setup cycle, one clock old.
    // Unmapped reads return zero so that no stale data leaks out with the error.
    if (psel && !penable) begin
      st_next.pslverr = !addr_hit(paddr);
      unique case (paddr)
        `RHCO_OFF_CTRL: st_next.prdata = {22'h00_0000, st_reg.ctrl};
        `RHCO_OFF_ROOM: st_next.prdata = {16'h0000, st_reg.room};
        `RHCO_OFF_SPHEAT: st_next.prdata = {16'h0000, st_reg.sp_heat};
        `RHCO_OFF_SPCOOL: st_next.prdata = {16'h0000, st_reg.sp_cool};
        `RHCO_OFF_WIDTH: st_next.prdata = {16'h0000, st_reg.width};
        `RHCO_OFF_THR: st_next.prdata = {24'h00_0000, st_reg.thr};
        `RHCO_OFF_CYCLE: st_next.prdata = {16'h0000, st_reg.cycle};
        `RHCO_OFF_GAIN: st_next.prdata = {16'h0000, st_reg.gain};
        `RHCO_OFF_VALUE: st_next.prdata = st_reg.value;
        `RHCO_OFF_OUT: st_next.prdata = {12'h000, st_reg.period_cnt, drv_w};
        default: st_next.prdata = 32'h0000_0000;
      endcase
    end
  end

  // State register.
  // Only constants are loaded in reset; the configuration words start at their power-up defaults.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.ctrl <= `RHCO_RST_CTRL;
      st_reg.room <= `RHCO_RST_ROOM;
      st_reg.sp_heat <= `RHCO_RST_SPHEAT;
      st_reg.sp_cool <= `RHCO_RST_SPCOOL;
      st_reg.width <= `RHCO_RST_WIDTH;
      st_reg.thr <= `RHCO_RST_THR;
      st_reg.cycle <= `RHCO_RST_CYCLE;
      st_reg.gain <= `RHCO_RST_GAIN;
    end else begin
      st_reg <= st_next;
    end
  end

  // One PWM channel per control algorithm, all fed from the shared period counter.
  // Each channel latches its own duty, so one channel's mode change never disturbs another.
  for (genvar g = 0; g < 4; g++) begin : g_chan
    rhco_pwm_if pif ();
    // Shared timing goes to every channel; only the value, the mode bit and the channel enable differ per channel.
    assign pif.period_start = st_reg.period_start;
    assign pif.period_cnt = st_reg.period_cnt;
    assign pif.cycle = cyc_eff;
    assign pif.value = st_reg.value[g];
    assign pif.switching = chan_switching(g, st_reg);
    assign pif.enable = chan_on(g, st_reg);
    assign pif.stat_en = st_reg.ctrl[`RHCO_CTRL_STAT];
    assign drv_w[g] = pif.drive;
    assign drv_send_w[g] = pif.drive_send;
    assign stat_w[g] = pif.status;
    assign stat_send_w[g] = pif.status_send;
    rhco_pwm_chan u_chan (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pif(pif.chan)
    );
  end

  // Zero wait states: the access phase always completes at once.
  // The continuous byte output shows the last value actually sent, not the running computation.
  // Send outputs come from flip-flops in a channel or in the state record; all are one-cycle pulses unless a channel stops the cycle after a period start.
  assign pready = psel && penable;
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr;
  assign cont_value = st_reg.last_sent;
  assign cont_send = st_reg.cont_send;
  assign thermal_valve_drive = drv_w;
  assign thermal_valve_send = drv_send_w;
  assign status_value = stat_w;
  assign status_send = stat_send_w;

endmodule

`default_nettype wire

// *** room_heat_command_output_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "rhco_defs.svh"

module room_heat_command_output_tb;
  localparam int TICK = 4;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, v;
  logic [31:0] pwdata, prdata, rd, wv;
  logic [3:0][7:0] cont_value, status_value;
  logic [3:0] cont_send, thermal_valve_drive, thermal_valve_send, status_send, valve;
  logic [15:0] heard, tg0;
  int bad_count, total_checks, seed, on, per, n, t0, e;
  int cyc = 0;
  int e_tab [3];
  logic [31:0] rst_tab [8] = '{`RHCO_RST_CTRL, `RHCO_RST_ROOM, `RHCO_RST_SPHEAT, `RHCO_RST_SPCOOL,
    `RHCO_RST_WIDTH, `RHCO_RST_THR, `RHCO_RST_CYCLE, `RHCO_RST_GAIN};

  rhco_top #(.TICK_CYCLES(TICK)) u_dut (.sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .cont_value, .cont_send, .thermal_valve_drive, .thermal_valve_send,
    .status_value, .status_send);
  rhco_act u_act (.sys_clk, .rstn, .drive(thermal_valve_drive), .send(thermal_valve_send), .valve, .heard);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen at a rising edge.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge sys_clk);
    end
    // A transfer that never completes counts as a mismatch.
    if (pready !== 1'b1) begin
      bad_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for a send pulse of channel 0, continuous (0) or status (1), giving up after lim cycles.
  task automatic wait_bit(input int which, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end while (!(which == 0 ? cont_send[0] : status_send[0]) && cnt < lim);
  endtask

  // Proportional part only, with the integral gain set to zero.
  function automatic logic [31:0] pi_val(input int err_in);
    int r;
    r = (err_in * 64) >>> 6;
    return (r < 0) ? 0 : (r > 255) ? 255 : r;
  endfunction

  initial begin
    #1_000_000;
    bad_count++;
    final_report;
  end

  initial begin
    seed = 52306;
    bad_count = 0;
    total_checks = 0;
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    for (n = 0; n < 8; n++) begin
      apb(8'(n * 4), 1'b0, 32'h0000_0000);
      check(rd, rst_tab[n]);
    end
    apb(8'h28, 1'b0, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    apb(8'h06, 1'b1, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    wv = $random(seed) & 32'h0000_ffff;
    apb(`RHCO_OFF_ROOM, 1'b1, wv);
    apb(`RHCO_OFF_ROOM, 1'b0, 32'h0000_0000);
    check(rd, wv);
    $display("test registers done");

    // Continuous byte: first send, exact 30 s spacing, then a step under the threshold.
    e = 20 + ($random(seed) & 63);
    apb(`RHCO_OFF_GAIN, 1'b1, 32'h0000_0040);
    apb(`RHCO_OFF_ROOM, 1'b1, 32'(16'h0834 - 16'(e)));
    apb(`RHCO_OFF_CTRL, 1'b1, 32'h0000_0003);
    wait_bit(0, 400, per);
    t0 = cyc;
    check(cont_value[0], pi_val(e));
    apb(`RHCO_OFF_ROOM, 1'b1, 32'(16'h0834 - 16'(e + 30)));
    wait_bit(0, 400, per);
    check(cyc - t0, 30 * TICK);
    check(cont_value[0], pi_val(e + 30));
    apb(`RHCO_OFF_ROOM, 1'b1, 32'(16'h0834 - 16'(e + 32)));
    wait_bit(0, 30 * TICK + 20, per);
    check(per, 30 * TICK + 20);
    check(cont_value[0], pi_val(e + 30));
    $display("test continuous done");

    // Switching: a random duty, full on, full off, over a four second period.
    e_tab = '{1 + ({$random(seed)} % 254), 300, -50};
    apb(`RHCO_OFF_CYCLE, 1'b1, 32'h0000_0004);
    apb(`RHCO_OFF_CTRL, 1'b1, 32'h0000_0223);
    for (n = 0; n < 3; n++) begin
      e = e_tab[n];
      apb(`RHCO_OFF_ROOM, 1'b1, 32'(16'h0834 - 16'(e)));
      repeat (30 * TICK + 40) @(posedge sys_clk);
      wait_bit(1, 100, per);
      v = status_value[0];
      tg0 = heard;
      on = 0;
      per = 0;
      do begin
        on += int'(thermal_valve_drive[0] === 1'b1);
        per++;
        @(posedge sys_clk);
        #1;
      end while (status_send[0] !== 1'b1 && per < 200);
      check(v, pi_val(e));
      check(per, 4 * TICK);
      check(on, ((pi_val(e) * 4) / 255) * TICK);
      check(32'(heard - tg0), (on > 0 && on < per) ? 2 : 1);
      check(valve[0], pi_val(e) == 255);
    end
    $display("test switching done");
    final_report;
  end
endmodule

bind rhco_top rhco_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.sys_clk, .rstn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .cont_value, .cont_send, .thermal_valve_drive,
  .thermal_valve_send, .status_value, .status_send);

`default_nettype wire
